// >>> regulator_i2c_slave_port_bench.sv
// Self-checking bench for the regulator two-wire slave port
`timescale 1ns/1ns
module regulator_i2c_slave_port_bench
    import rsp_pkg::*;
;
    // ====================
    // Signals
    logic clk, rst_n, sda, sdaOut, sdaOe, writeStrobe, busBusy;
    logic sclClk, sdaPull, enable, softStartDone;
    logic [1:0] addressSelectPin;
    rsp_telem_t telem;
    rsp_ctrl_t ctrl;
    logic [7:0] regs [0:7];
    logic [6:0] myAddr;
    int fails, nTests, strobes;

    // Open-drain wire with pull-up
    assign sda = ~(sdaPull | (sdaOe & ~sdaOut));

    rsp_i2c_slave u_dut (.clk(clk), .rst_n(rst_n), .sclClk(sclClk),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addressSelectPin(addressSelectPin), .enable(enable),
        .softStartDone(softStartDone), .telem(telem), .ctrl(ctrl),
        .writeStrobe(writeStrobe), .busBusy(busBusy));
    rsp_bus_master u_master (.sda(sda), .scl(sclClk), .sdaPull(sdaPull));

    // System clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Commit pulses counted for the model
    always @(posedge clk)
        if (writeStrobe === 1'h1)
            strobes <= strobes + 1;

    // ====================
    // Checking and closing
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    begin
        nTests++;
        if (got !== exp)
        begin
            $display("Error %s expected %0h seen %0h", what, exp, got);
            fails++;
        end
    end
    endtask

    task automatic closeOut();
    begin
        $display("Comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // ====================
    // Transfers; hit says whether the port should answer
    task automatic wr(input logic [6:0] sa, input logic [7:0] ra,
                      input logic [7:0] d, input logic hit);
        logic [7:0] rx;
        logic a0, a1, a2;
        int s0;
    begin
        s0 = strobes;
        u_master.do_start();
        check("busy", 1'h1, busBusy);
        u_master.xfer({sa, 1'h0}, 1'h1, rx, a0);
        u_master.xfer(ra, 1'h1, rx, a1);
        u_master.xfer(d, 1'h1, rx, a2);
        u_master.do_stop();
        check("busy", 0, busBusy);
        check("ack", {3{~hit}}, {a0, a1, a2});
        if (hit && ra < 8'h03)
            regs[ra] = d;
        if (hit || ra < 8'h03)
            check("strobes", hit, strobes - s0);
        check("ctrl", {regs[2], regs[1], regs[0]}, ctrl);
    end
    endtask

    // Pointer write, repeated start, two reads, master declines a third
    task automatic rd(input logic [2:0] ra);
        logic [7:0] rx;
        logic a;
    begin
        u_master.do_start();
        u_master.xfer({myAddr, 1'h0}, 1'h1, rx, a);
        u_master.xfer({5'h00, ra}, 1'h1, rx, a);
        u_master.do_start();
        check("busy", 1, busBusy);
        u_master.xfer({myAddr, 1'h1}, 1'h1, rx, a);
        check("rack", 0, a);
        // Master acks once, so the same register comes out twice
        u_master.xfer(8'hFF, 1'h0, rx, a);
        check("rdata", regs[ra], rx);
        u_master.xfer(8'hFF, 1'h1, rx, a);
        u_master.do_stop();
        check("rdata", regs[ra], rx);
    end
    endtask

    // ====================
    // Main sequence
    initial
    begin
        fails = 0;
        nTests = 0;
        strobes = 0;
        rst_n = 1'h0;
        enable = 1'h0;
        softStartDone = 1'h1;
        addressSelectPin = 2'h0;
        void'($urandom(48));
        telem = $urandom();
        regs = '{VSEL_RST, CTRL1_RST, CTRL2_RST, telem.current,
                 telem.voltage, telem.ident, telem.status, 8'h00};
        repeat (12) @(posedge clk);
        #2 rst_n = 1'h1;
        check("reset", WR_RST, ctrl);
        // Silent until enabled and soft start done
        wr(7'h61, 8'h00, 8'h5A, 1'h0);
        @(posedge clk);
        #2 enable = 1'h1;
        softStartDone = 1'h0;
        wr(7'h61, 8'h01, 8'h5A, 1'h0);
        @(posedge clk);
        #2 softStartDone = 1'h1;
        repeat (5) @(posedge clk);
        // Each select level, own address and a neighbour's
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            #2 addressSelectPin = s[1:0];
            myAddr = 7'h61 + {s[1:0], 1'h0};
            wr(myAddr, s % 3, $urandom(), 1'h1);
            wr(myAddr ^ 7'h02, s % 3, $urandom(), 1'h0);
        end
        // Read-only place takes the byte but keeps its value
        wr(myAddr, 8'h04, 8'hC3, 1'h1);
        // All registers and the first unmapped place read back
        for (int r = 0; r < 8; r++)
            rd(r[2:0]);
        closeOut();
    end

    // Watchdog against a hung transfer
    initial
    begin
        #500000;
        fails++;
        closeOut();
    end
endmodule

// >>> rsp_bus_master.sv
// Behavioural two-wire bus master making the link clock and data traffic
`timescale 1ns/1ns
module rsp_bus_master
(
    // Resolved data line
    input wire logic sda,
    // Link clock and data pull-down
    output logic scl,
    output logic sdaPull
);
    // ====================
    // Timing; low phase kept above the 60 ns the slave needs
    localparam int HALF = 64;

    // Clock idles high, stands still between frames
    initial
    begin
        scl = 1'h1;
        sdaPull = 1'h0;
    end

    // Start or repeated start; late release lets an ack clear first
    task automatic do_start();
    begin
        #(HALF / 2) sdaPull = 1'h0;
        #(HALF / 2) scl = 1'h1;
        #(HALF) sdaPull = 1'h1;
        #(HALF) scl = 1'h0;
    end
    endtask

    // Stop, then the bus-free gap
    task automatic do_stop();
    begin
        #(HALF / 2) sdaPull = 1'h1;
        #(HALF / 2) scl = 1'h1;
        #(HALF) sdaPull = 1'h0;
        #4700;
    end
    endtask

    // One bit: data set in low phase, sampled mid high phase
    task automatic clock_bit(input logic b, output logic r);
    begin
        #(HALF / 2) sdaPull = ~b;
        #(HALF / 2) scl = 1'h1;
        #(HALF / 2) r = sda;
        #(HALF / 2) scl = 1'h0;
    end
    endtask

    // Eight bits MSB first, then the ack clock from the master
    task automatic xfer(input logic [7:0] tx, input logic ackOut,
                        output logic [7:0] rx, output logic ack);
    begin
        for (int i = 7; i >= 0; i--)
            clock_bit(tx[i], rx[i]);
        clock_bit(ackOut, ack);
    end
    endtask
endmodule

// >>> rsp_i2c_slave.sv
// Two-wire slave port giving a bus master access to regulator registers
// Notes on behaviour
// (RULE1) One of four slave addresses, pin selected
// (RULE2) Select level maps to 61h, 63h, 65h, 67h
// (RULE3) First byte: address then direction bit
// (RULE4) Data changes only while clock low
// (RULE5) Detect start and stop conditions
// (RULE6) Master alone makes start, stop, clock
// (RULE7) Bus free 4.7us after stop
// (RULE8) Repeated start handled like start
// (RULE9) Eight bits, MSB first, then acknowledge
// (RULE10) Receiver holds data low during acknowledge
// (RULE11) Master clocks every acknowledge bit
// (RULE12) Transfer ends with stop or repeated start
// (RULE13) Update: address, register byte, data byte
// (RULE14) Acknowledge every received byte
// (RULE15) Take part only on address match
// (RULE16) Commit write at data LSB falling edge
// (RULE17) Device never drives the clock line
// (RULE18) Port usable only after enable, soft start
// (RULE19) Seven registers, 00-02 writable, rest read-only
// (RULE20) Mismatch: release line, ignore until start
// (RULE21) Reads return register at last pointer
`timescale 1ns/1ns
module rsp_i2c_slave
    import rsp_pkg::*;
(
    // System clock and reset
    input logic clk,
    input logic rst_n,
    // Link clock from the master, clocks the bit sampler
    input logic sclClk,
    // Open-drain data line
    input logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Decoded level of the address select pin
    input logic [1:0] addressSelectPin,
    // Regulator state
    input logic enable,
    input logic softStartDone,
    input rsp_telem_t telem,
    // Register values and status
    output rsp_ctrl_t ctrl,
    output logic writeStrobe,
    output logic busBusy
);

    // ==========================================================
    // Link domain: data sampled on the rising link clock
    // The master guarantees setup around this edge, so this is the
    // proper sampling point; no synchroniser is wanted here.
    logic [7:0] linkShift;

    always_ff @(posedge sclClk or negedge rst_n)
    begin
        if (!rst_n)
            linkShift <= 8'h00;
        else
            linkShift <= {linkShift[6:0], sdaIn}; // RULE9
    end

    // ==========================================================
    // System domain: two-flop synchronisers for pins and link clock
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    logic sclPrev;
    logic sdaPrev;

    wire [SYNC_W-1:0] pinsRaw = {sclClk, sdaIn, enable, softStartDone,
                                 addressSelectPin};

    // Lines reset to idle high so leaving reset makes no false edge;
    // the edge stage reads only the settled second copy
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA <= SYNC_RST;
            syncB <= SYNC_RST;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            syncA <= pinsRaw;
            syncB <= syncA;
            sclPrev <= syncB[5];
            sdaPrev <= syncB[4];
        end
    end

    // ==========================================================
    // Line events decoded from the synchronised copies
    wire sclS = syncB[5];
    wire sdaS = syncB[4];
    wire enS = syncB[3];
    wire ssDoneS = syncB[2];
    wire [1:0] selS = syncB[1:0];

    wire sclRise = sclS & ~sclPrev;
    wire sclFall = ~sclS & sclPrev;
    wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS; // RULE5 RULE8
    wire stopSeen = sclS & sclPrev & ~sdaPrev & sdaS; // RULE5
    // Without traffic the regulator runs from its divider setting;
    // the port wakes only once start-up is over.
    wire portReady = enS & ssDoneS; // RULE18
    wire [6:0] selAddr = ADDR_TABLE[selS]; // RULE1 RULE2

    // ==========================================================
    // Protocol state
    rsp_state_t state;
    rsp_state_t next_state;
    logic [3:0] bitCnt;
    logic [3:0] next_bitCnt;
    logic [1:0] byteIdx;
    logic [1:0] next_byteIdx;
    logic rwRead;
    logic next_rwRead;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    logic [7:0] rxHold;
    logic [7:0] next_rxHold;
    logic [7:0] txByte;
    logic [7:0] next_txByte;
    logic [6:0] devAddr;
    logic [6:0] next_devAddr;
    logic masterAck;
    logic next_masterAck;
    logic next_sdaOe;
    logic next_wrEn;
    logic [7:0] rdData;

    wire addrMatch = (rxHold[7:1] == devAddr); // RULE15
    wire byteDone = sclFall && (bitCnt == BIT_LAST);
    wire [1:0] idxStep = (byteIdx == IDX_DATA) ? byteIdx : byteIdx + 2'h1;

    // ==========================================================
    // Next-state decision; line drive only changes after a falling
    // clock, except the release when the port is not ready, so the data line
    // is steady through every high phase while the port stays ready.
    always_comb
    begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_byteIdx = byteIdx;
        next_rwRead = rwRead;
        next_pointer = pointer;
        next_rxHold = rxHold;
        next_txByte = txByte;
        next_devAddr = devAddr;
        next_masterAck = masterAck;
        next_sdaOe = sdaOe;
        next_wrEn = 1'b0;
        if (!portReady)
        begin
            next_state = ST_IDLE; // RULE18
            next_sdaOe = 1'b0;
        end
        else if (startSeen)
        begin
            // A repeated start restarts framing exactly like a start
            next_state = ST_RX; // RULE8
            next_bitCnt = 4'h0;
            next_byteIdx = IDX_ADDR;
            next_devAddr = selAddr; // RULE1
            next_sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            next_state = ST_IDLE; // RULE12
            next_sdaOe = 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    next_sdaOe = 1'b0; // RULE20
                end
                ST_RX:
                begin
                    if (sclRise)
                        next_bitCnt = bitCnt + 4'h1; // RULE9
                    else if (byteDone)
                    begin
                        // Sampler is steady until the next rising clock
                        next_rxHold = linkShift;
                        next_state = ST_DECIDE;
                    end
                end
                ST_DECIDE:
                begin
                    next_bitCnt = 4'h0;
                    next_byteIdx = idxStep;
                    if (byteIdx == IDX_ADDR)
                    begin
                        if (addrMatch)
                        begin
                            next_rwRead = rxHold[0]; // RULE3
                            next_sdaOe = 1'b1; // RULE14
                            next_state = ST_ACK;
                        end
                        else
                        begin
                            next_sdaOe = 1'b0; // RULE20
                            next_state = ST_IDLE;
                        end
                    end
                    else if (byteIdx == IDX_POINTER)
                    begin
                        next_pointer = rxHold; // RULE13 RULE21
                        next_sdaOe = 1'b1; // RULE14
                        next_state = ST_ACK;
                    end
                    else
                    begin
                        next_wrEn = 1'b1; // RULE16
                        next_sdaOe = 1'b1; // RULE14
                        next_state = ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    // Held low through the whole acknowledge high phase
                    if (sclFall)
                    begin
                        if (rwRead)
                        begin
                            next_txByte = rdData; // RULE21
                            next_sdaOe = ~rdData[7]; // RULE4
                            next_state = ST_TX;
                        end
                        else
                        begin
                            next_sdaOe = 1'b0; // RULE10
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclRise)
                        next_bitCnt = bitCnt + 4'h1;
                    else if (byteDone)
                    begin
                        next_sdaOe = 1'b0; // RULE10
                        next_bitCnt = 4'h0;
                        next_state = ST_TXACK;
                    end
                    else if (sclFall)
                    begin
                        next_txByte = {txByte[6:0], 1'b0};
                        next_sdaOe = ~txByte[6]; // RULE4 RULE9
                    end
                end
                ST_TXACK:
                begin
                    if (sclRise)
                        next_masterAck = ~sdaS;
                    else if (sclFall)
                    begin
                        if (masterAck)
                        begin
                            // Same register again; no auto-increment
                            next_txByte = rdData; // RULE21
                            next_sdaOe = ~rdData[7];
                            next_state = ST_TX;
                        end
                        else
                        begin
                            next_sdaOe = 1'b0;
                            next_state = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_sdaOe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Protocol registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            byteIdx <= IDX_ADDR;
            rwRead <= 1'b0;
            pointer <= 8'h00;
        end
        else
        begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            byteIdx <= next_byteIdx;
            rwRead <= next_rwRead;
            pointer <= next_pointer;
        end
    end

    // Data path registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxHold <= 8'h00;
            txByte <= 8'h00;
            devAddr <= ADDR_TABLE[0];
            masterAck <= 1'b0;
        end
        else
        begin
            rxHold <= next_rxHold;
            txByte <= next_txByte;
            devAddr <= next_devAddr;
            masterAck <= next_masterAck;
        end
    end

    // ==========================================================
    // Line drive; only data is ever driven, never the clock line
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            writeStrobe <= 1'b0;
        end
        else
        begin
            sdaOe <= next_sdaOe; // RULE17
            sdaOut <= 1'b0; // Open drain: only ever pulls low
            writeStrobe <= next_wrEn; // RULE16
        end
    end

    // Busy from any start until a stop; free time is the master's care
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busBusy <= 1'b0;
        else if (startSeen)
            busBusy <= 1'b1; // RULE8
        else if (stopSeen)
            busBusy <= 1'b0; // RULE7
    end

    // ==========================================================
    // Register file
    rsp_regmem uRegs (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(writeStrobe),
        .addr(pointer),
        .wrData(rxHold),
        .rdData(rdData),
        .telem(telem),
        .ctrl(ctrl)
    );

endmodule

// >>> rsp_i2c_slave_assertions.sv
// Concurrent checks on the two-wire slave port
`timescale 1ns/1ns
module rsp_i2c_slave_assertions
    import rsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Regulator side
    input wire logic enable,
    input wire logic softStartDone,
    input wire rsp_ctrl_t ctrl,
    input wire logic writeStrobe,
    input wire logic busBusy
);
    // ====================
    // Clocking, one domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ====================
    // Line behaviour
    AST_OE_ONLY_LOW: assert property (sdaOe |-> sdaOut == 1'h0)
        else $error("data pin driven high");
    AST_OE_IN_LOW: assert property ($changed(sdaOe) |-> !sclClk)
        else $error("data pin changed while clock high");
    AST_IDLE_RELEASED: assert property (!busBusy |-> !sdaOe)
        else $error("data pin driven on idle bus");
    AST_DISABLED_SILENT: assert property ((!enable)[*5] |-> !sdaOe)
        else $error("data pin driven while disabled");
    // Conditions are seen through a short synchroniser, hence the window
    AST_START_BUSY: assert property (enable && softStartDone && sclClk
        && $fell(sdaIn) |-> ##[1:5] busBusy)
        else $error("start not seen");
    AST_STOP_FREE: assert property (sclClk && $rose(sdaIn)
        |-> ##[1:5] !busBusy)
        else $error("stop not seen");

    // ====================
    // Register commit
    AST_STROBE_PULSE: assert property (writeStrobe |=> !writeStrobe)
        else $error("write strobe longer than one cycle");
    AST_STROBE_BUSY: assert property (writeStrobe |-> busBusy)
        else $error("write strobe outside a transfer");
    AST_CTRL_AFTER_STROBE: assert property ($changed(ctrl)
        |-> $past(writeStrobe))
        else $error("register changed without a commit");

    // Main scenarios reached
    cover property (writeStrobe);
    cover property ($rose(sdaOe));
    cover property ($fell(busBusy));
endmodule

bind rsp_i2c_slave rsp_i2c_slave_assertions u_check (.clk(clk),
    .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .enable(enable), .softStartDone(softStartDone),
    .ctrl(ctrl), .writeStrobe(writeStrobe), .busBusy(busBusy));

// >>> rsp_pkg.sv
// Shared constants and types of the regulator two-wire slave port
package rsp_pkg;

    // ==========================================================
    // Register map
    localparam int REG_COUNT = 7;
    localparam int WR_COUNT = 3;
    localparam logic [7:0] REG_VSEL = 8'h00;
    localparam logic [7:0] REG_CTRL1 = 8'h01;
    localparam logic [7:0] REG_CTRL2 = 8'h02;
    localparam logic [7:0] REG_CURRENT = 8'h03;
    localparam logic [7:0] REG_VOLTAGE = 8'h04;
    localparam logic [7:0] REG_IDENT = 8'h05;
    localparam logic [7:0] REG_STATUS = 8'h06;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ==========================================================
    // Values after reset of the writable registers
    localparam logic [7:0] VSEL_RST = 8'h9E;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [WR_COUNT-1:0][7:0] WR_RST = {CTRL2_RST, CTRL1_RST,
                                                   VSEL_RST};

    // ==========================================================
    // Framing
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_POINTER = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;
    localparam int SYNC_W = 6;
    // Clock and data lines idle high, the other pins low
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h30;

    // ==========================================================
    // Slave address per decoded address-select level
    // Level 0 floating, 1 500k/300k, 2 300k/500k, 3 pull-up only
    localparam logic [3:0][6:0] ADDR_TABLE = {7'h67, 7'h65, 7'h63, 7'h61};

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] ctrl2;
        logic [7:0] ctrl1;
        logic [7:0] vsel;
    } rsp_ctrl_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] ident;
        logic [7:0] voltage;
        logic [7:0] current;
    } rsp_telem_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_DECIDE,
        ST_ACK,
        ST_TX,
        ST_TXACK
    } rsp_state_t;

endpackage

// >>> rsp_regmem.sv
// Byte register file behind the slave port, with registered read data
`timescale 1ns/1ns
module rsp_regmem
    import rsp_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Access from the port
    input logic wrEn,
    input logic [7:0] addr,
    input logic [7:0] wrData,
    output logic [7:0] rdData,
    // Regulator side
    input rsp_telem_t telem,
    output rsp_ctrl_t ctrl
);

    // ==========================================================
    // Writable registers 00 to 02
    logic [WR_COUNT-1:0][7:0] rwReg;

    genvar i;
    generate
        for (i = 0; i < WR_COUNT; i++)
        begin : gWr
            // Writes to read-only or unmapped offsets never land here
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    rwReg[i] <= WR_RST[i];
                else if (wrEn && addr == 8'(i))
                    rwReg[i] <= wrData; // RULE19
            end
        end
    endgenerate

    assign ctrl = rsp_ctrl_t'(rwReg);

    // ==========================================================
    // Read selection, read-only offsets show the regulator state
    wire [7:0] rdNext =
        (addr == REG_VSEL)    ? rwReg[0] :
        (addr == REG_CTRL1)   ? rwReg[1] :
        (addr == REG_CTRL2)   ? rwReg[2] :
        (addr == REG_CURRENT) ? telem.current :
        (addr == REG_VOLTAGE) ? telem.voltage :
        (addr == REG_IDENT)   ? telem.ident :
        (addr == REG_STATUS)  ? telem.status : RD_UNMAPPED; // RULE19

    // Registered so the byte is settled long before it is shifted out
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdData <= RD_UNMAPPED;
        else
            rdData <= rdNext;
    end

endmodule
